// File: dma_seq.sv
// Function
// - pointers and counter are 24 bits; software writes all bits.
// - requests accepted only after permission bit set, set last.
// - control bit 0 selects priority scheme, bit 1 terminal-count validity.
// - normal count reaching zero drives terminal count low and sets interrupt.
// - normal completion clears permission; burst also clears request flag.
// - external terminal count low or permission cleared halts, no interrupt.
// - falling edge on external request pin sets request flag.
// - accept only without refresh request and without bus hold.
// - higher-priority pending channel is served first.
// - read cycle drives source address, rw high, steps pointer, latches data.
// - write cycle drives destination address, rw low, latched data, steps pointer.
// - unaligned 16-bit unit splits into two byte accesses.
// - counter decremented by 1 or 2 alongside source address output.
// - first written values kept in latches; permission restart reuses them.
// - repeat keeps permission at zero count; burst keeps request flag.
// - repeat with cycle steal clears request flag after every unit.
// - repeat reloads from latches at end; burst repeats, steal waits.
// - repeat never drives terminal count nor sets interrupt.
// - fixed priority ranks 0,1,2,3 and is selected after reset.
// - mode bits 4-5 source direction, bits 6-7 destination direction.
`default_nettype none
module dma_seq
    import dma_pkg::*;
(
    input  wire logic                ref_clk,
    input  wire logic                rstn,
    // software setup
    input  wire logic                sw_wr,
    input  wire logic [CHW-1:0]      sw_wr_ch,
    input  wire sw_sel_t             sw_wr_sel,
    input  wire logic [AW-1:0]       sw_wr_data,
    input  wire logic                ctrl_wr,
    input  wire logic [7:0]          ctrl_wdata,
    input  wire logic [NCH-1:0]      perm_set,
    input  wire logic [NCH-1:0]      perm_clr,
    input  wire mode_t [NCH-1:0]     chan_mode,
    // request sources and gating
    input  wire logic [NCH-1:0]      ext_transfer_request_n,
    input  wire logic                refresh_req,
    input  wire logic                bus_hold_request,
    // terminal count pin, open drain
    input  wire logic                terminal_count_line_i,
    output logic                     terminal_count_line_o,
    output logic                     terminal_count_line_oe_n,
    // system bus master
    output bus_out_t                 bus_o,
    input  wire logic [DW-1:0]       bus_rdata,
    input  wire logic                bus_ack,
    // status
    output logic [7:0]               ctrl_r,
    output logic [NCH-1:0]           perm_r,
    output logic [NCH-1:0]           req_flag_r,
    output logic [NCH-1:0]           irq_set_r,
    output logic [CHW-1:0]           active_ch_r,
    output logic                     busy_r
);
    typedef enum logic [1:0] {
        S_IDLE,
        S_RD,
        S_WR
    } st_t;

    st_t             st_r;
    logic [AW-1:0]   sp_r   [NCH];
    logic [AW-1:0]   dp_r   [NCH];
    logic [AW-1:0]   cnt_r  [NCH];
    logic [AW-1:0]   sp_lat [NCH];
    logic [AW-1:0]   dp_lat [NCH];
    logic [AW-1:0]   cnt_lat[NCH];
    logic [DW-1:0]   lat_r;
    logic            half_r;
    logic            split_r;
    logic            zero_r;
    logic [CHW-1:0]  prio_top_r;
    logic [TC_MASK_W-1:0] tc_own_r;

    // synchronisers for pins
    logic [NCH-1:0]  req_s1;
    logic [NCH-1:0]  req_s2;
    logic [NCH-1:0]  req_s3;
    logic            tc_s1;
    logic            tc_s2;
    logic            hold_s1;
    logic            hold_s2;

    // combinational decisions
    logic [NCH-1:0]  eligible;
    logic            grant_vld;
    logic [CHW-1:0]  grant;
    logic [CHW-1:0]  ev_ch;
    logic            ev_src;
    logic            ev_dst;
    logic            ev_cnt;
    logic            ev_reload;
    logic            ev_perm_clr;
    logic            ev_req_clr;
    logic            ev_normal_done;
    logic            ext_halt;
    logic            halt_now;
    logic            last_acc;
    logic            start;
    mode_t           cur_mode;
    mode_t           grant_mode;
    logic [1:0]      acc_amt;
    logic [1:0]      cnt_amt;
    logic [AW-1:0]   astep;
    logic [AW-1:0]   cstep;
    dir_t            adir;
    logic [DW-1:0]   lat_nxt;

    // two flops before any logic reads a pin
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            req_s1  <= 4'hF;
            req_s2  <= 4'hF;
            req_s3  <= 4'hF;
            tc_s1   <= 1'b1;
            tc_s2   <= 1'b1;
            hold_s1 <= 1'b0;
            hold_s2 <= 1'b0;
        end else begin
            req_s1  <= ext_transfer_request_n;
            req_s2  <= req_s1;
            req_s3  <= req_s2;
            tc_s1   <= terminal_count_line_i;
            tc_s2   <= tc_s1;
            hold_s1 <= bus_hold_request;
            hold_s2 <= hold_s1;
        end
    end

    assign cur_mode   = chan_mode[active_ch_r];
    assign grant_mode = chan_mode[grant];

    // own low drive echoes back through the synchroniser, so mask it
    assign ext_halt = !tc_s2 && (tc_own_r == 3'h0) && terminal_count_line_oe_n;
    assign halt_now = ext_halt || !perm_r[active_ch_r];

    // rotating search from the current top channel
    always_comb begin
        grant_vld = 1'b0;
        grant     = CH_RST;
        for (int k = NCH - 1; k >= 0; k--) begin
            logic [CHW-1:0] idx;
            idx = prio_top_r + k[CHW-1:0];
            if (eligible[idx]) begin
                grant_vld = 1'b1;
                grant     = idx;
            end
        end
    end

    assign eligible = perm_r & req_flag_r;
    assign start = (st_r == S_IDLE) && grant_vld && !refresh_req && !hold_s2;

    // access size: split halves and byte units move one byte, whole 16-bit units two
    assign acc_amt  = (bus_o.word || !cur_mode.unit16) ? STEP_TWO - {1'b0, !bus_o.word} :
                      STEP_ONE;
    assign cnt_amt  = grant_mode.unit16 ? STEP_TWO : STEP_ONE;
    assign adir     = (st_r == S_WR) ? cur_mode.dst_dir : cur_mode.src_dir;
    assign last_acc = !split_r || half_r;

    dma_step addr_step_unit (
        .val (bus_o.addr),
        .dir (adir),
        .amt (acc_amt),
        .res (astep)
    );

    dma_step count_step_unit (
        .val (cnt_r[grant]),
        .dir (DIR_BWD),
        .amt (cnt_amt),
        .res (cstep)
    );

    // byte lanes gather into the data latch, low byte first
    always_comb begin
        lat_nxt = lat_r;
        if (bus_o.word) begin
            lat_nxt = bus_rdata;
        end else if (half_r) begin
            lat_nxt[15:8] = bus_rdata[7:0];
        end else begin
            lat_nxt[7:0] = bus_rdata[7:0];
        end
    end

    // per-unit events toward the channel registers
    always_comb begin
        ev_ch          = (st_r == S_IDLE) ? grant : active_ch_r;
        ev_cnt         = start;
        ev_src         = (st_r == S_RD) && bus_ack;
        ev_dst         = (st_r == S_WR) && bus_ack;
        ev_reload      = 1'b0;
        ev_perm_clr    = 1'b0;
        ev_req_clr     = 1'b0;
        ev_normal_done = 1'b0;
        if ((st_r == S_WR) && bus_ack && last_acc) begin
            if (zero_r && cur_mode.repeat_en) begin
                ev_reload  = 1'b1;
                ev_req_clr = !cur_mode.burst;
            end else if (zero_r) begin
                ev_perm_clr    = 1'b1;
                ev_req_clr     = cur_mode.burst;
                ev_normal_done = 1'b1;
            end else begin
                ev_req_clr = !cur_mode.burst;
            end
        end
        if (ext_halt && (st_r != S_IDLE)) begin
            ev_perm_clr = 1'b1;
        end
    end

    // channel registers: software writes, stepping and reload
    for (genvar i = 0; i < NCH; i++) begin : g_ch
        always_ff @(posedge ref_clk or negedge rstn) begin
            if (!rstn) begin
                sp_r[i]    <= PTR_RST;
                dp_r[i]    <= PTR_RST;
                cnt_r[i]   <= CNT_ZERO;
                sp_lat[i]  <= PTR_RST;
                dp_lat[i]  <= PTR_RST;
                cnt_lat[i] <= CNT_ZERO;
            end else if (sw_wr && (sw_wr_ch == i[CHW-1:0])) begin
                case (sw_wr_sel)
                    SEL_SRC: begin
                        sp_r[i]   <= sw_wr_data;
                        sp_lat[i] <= sw_wr_data;
                    end
                    SEL_DST: begin
                        dp_r[i]   <= sw_wr_data;
                        dp_lat[i] <= sw_wr_data;
                    end
                    SEL_CNT: begin
                        cnt_r[i]   <= sw_wr_data;
                        cnt_lat[i] <= sw_wr_data;
                    end
                    default: begin
                    end
                endcase
            end else if ((ev_reload && (ev_ch == i[CHW-1:0])) || perm_set[i]) begin
                sp_r[i]  <= sp_lat[i];
                dp_r[i]  <= dp_lat[i];
                cnt_r[i] <= cnt_lat[i];
            end else if (ev_ch == i[CHW-1:0]) begin
                if (ev_src) begin
                    sp_r[i] <= astep;
                end
                if (ev_dst) begin
                    dp_r[i] <= astep;
                end
                if (ev_cnt) begin
                    cnt_r[i] <= cstep;
                end
            end
        end

        // permission: software set wins over any clear
        always_ff @(posedge ref_clk or negedge rstn) begin
            if (!rstn) begin
                perm_r[i] <= 1'b0;
            end else if (perm_set[i]) begin
                perm_r[i] <= 1'b1;
            end else if (perm_clr[i] || (ev_perm_clr && (ev_ch == i[CHW-1:0]))) begin
                perm_r[i] <= 1'b0;
            end
        end

        // request flag: a falling edge wins over a same-cycle clear
        always_ff @(posedge ref_clk or negedge rstn) begin
            if (!rstn) begin
                req_flag_r[i] <= 1'b0;
            end else if (req_s3[i] && !req_s2[i]) begin
                req_flag_r[i] <= 1'b1;
            end else if (ev_req_clr && (ev_ch == i[CHW-1:0])) begin
                req_flag_r[i] <= 1'b0;
            end
        end
    end

    // control register, fixed priority after reset
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            ctrl_r <= CTRL_RST;
        end else if (ctrl_wr) begin
            ctrl_r <= ctrl_wdata;
        end
    end

    // rotation only on normal completion; forced halts leave it
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            prio_top_r <= CH_RST;
        end else if (!ctrl_r[CTRL_PRIO_BIT]) begin
            prio_top_r <= CH_RST;
        end else if (ev_normal_done) begin
            prio_top_r <= active_ch_r + 2'h1;
        end
    end

    // terminal count drive and interrupt pulse
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            terminal_count_line_o    <= 1'b0;
            terminal_count_line_oe_n <= 1'b1;
            tc_own_r                 <= 3'h0;
            irq_set_r                <= FLAG_RST;
        end else begin
            terminal_count_line_o <= 1'b0;
            irq_set_r             <= FLAG_RST;
            tc_own_r              <= {tc_own_r[TC_MASK_W-2:0], 1'b0};
            terminal_count_line_oe_n <= 1'b1;
            if (ev_normal_done) begin
                irq_set_r[active_ch_r]   <= 1'b1;
                terminal_count_line_oe_n <= !ctrl_r[CTRL_TCV_BIT];
                if (ctrl_r[CTRL_TCV_BIT]) begin
                    tc_own_r <= TC_MASK_SET;
                end
            end
        end
    end

    // transfer sequencer
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            st_r        <= S_IDLE;
            active_ch_r <= CH_RST;
            busy_r      <= 1'b0;
            half_r      <= 1'b0;
            split_r     <= 1'b0;
            zero_r      <= 1'b0;
            lat_r       <= DATA_RST;
            bus_o       <= '0;
        end else begin
            case (st_r)
                S_IDLE: begin
                    if (start) begin
                        st_r         <= S_RD;
                        busy_r       <= 1'b1;
                        active_ch_r  <= grant;
                        half_r       <= 1'b0;
                        split_r      <= grant_mode.unit16 &&
                                        (sp_r[grant][0] ^ (grant_mode.src_dir == DIR_BWD));
                        zero_r       <= (cstep == CNT_ZERO);
                        bus_o.addr   <= sp_r[grant];
                        bus_o.rw     <= 1'b1;
                        bus_o.word   <= grant_mode.unit16 &&
                                        !(sp_r[grant][0] ^ (grant_mode.src_dir == DIR_BWD));
                        bus_o.strobe <= 1'b1;
                    end
                end
                S_RD: begin
                    if (bus_ack) begin
                        lat_r <= lat_nxt;
                        if (!last_acc) begin
                            half_r     <= 1'b1;
                            bus_o.addr <= astep;
                        end else if (halt_now) begin
                            st_r         <= S_IDLE;
                            busy_r       <= 1'b0;
                            bus_o.strobe <= 1'b0;
                        end else begin
                            st_r        <= S_WR;
                            half_r      <= 1'b0;
                            split_r     <= cur_mode.unit16 &&
                                           (dp_r[active_ch_r][0] ^
                                            (cur_mode.dst_dir == DIR_BWD));
                            bus_o.addr  <= dp_r[active_ch_r];
                            bus_o.rw    <= 1'b0;
                            bus_o.word  <= cur_mode.unit16 &&
                                           !(dp_r[active_ch_r][0] ^
                                             (cur_mode.dst_dir == DIR_BWD));
                            bus_o.wdata <= lat_nxt;
                        end
                    end
                end
                S_WR: begin
                    if (bus_ack) begin
                        if (!last_acc) begin
                            half_r      <= 1'b1;
                            bus_o.addr  <= astep;
                            bus_o.wdata <= {8'h00, lat_r[15:8]};
                        end else begin
                            st_r         <= S_IDLE;
                            busy_r       <= 1'b0;
                            bus_o.strobe <= 1'b0;
                            bus_o.rw     <= 1'b1;
                        end
                    end
                end
                default: begin
                    st_r <= S_IDLE;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// File: dma_pkg.sv
`default_nettype none
package dma_pkg;
    // channel count and bus widths
    localparam int NCH = 4;
    localparam int CHW = 2;
    localparam int AW  = 24;
    localparam int DW  = 16;

    // channel_control_regs field positions and reset value
    localparam int          CTRL_PRIO_BIT = 0;
    localparam int          CTRL_TCV_BIT  = 1;
    localparam logic [7:0]  CTRL_RST      = 8'h00;

    // reset values of pointers, counter and flags
    localparam logic [AW-1:0]  PTR_RST  = 24'h000000;
    localparam logic [AW-1:0]  CNT_ZERO = 24'h000000;
    localparam logic [NCH-1:0] FLAG_RST = 4'h0;
    localparam logic [CHW-1:0] CH_RST   = 2'h0;
    localparam logic [DW-1:0]  DATA_RST = 16'h0000;

    // step amounts for one byte or one 16-bit unit
    localparam logic [1:0] STEP_ONE = 2'h1;
    localparam logic [1:0] STEP_TWO = 2'h2;

    // cycles that the own terminal-count drive is masked from the input
    localparam int         TC_PULSE_NS = 8;
    localparam int         CLK_NS      = 8;
    localparam int         TC_PULSE_CY = (TC_PULSE_NS + CLK_NS - 1) / CLK_NS;
    localparam int         TC_MASK_W   = 3;
    localparam logic [2:0] TC_MASK_SET = 3'h7;

    // address change direction, per_channel_mode bits 4-5 and 6-7
    typedef enum logic [1:0] {
        DIR_FWD,
        DIR_BWD,
        DIR_FIX,
        DIR_FIX2
    } dir_t;

    // per_channel_mode layout, bit 0 at the right
    typedef struct packed {
        dir_t dst_dir;   // bits 7:6
        dir_t src_dir;   // bits 5:4
        logic rsv3;      // bit 3
        logic burst;     // bit 2, 0 = cycle steal
        logic repeat_en; // bit 1, 0 = normal
        logic unit16;    // bit 0
    } mode_t;

    // software write target
    typedef enum logic [1:0] {
        SEL_SRC,
        SEL_DST,
        SEL_CNT
    } sw_sel_t;

    // system bus master outputs
    typedef struct packed {
        logic [AW-1:0] addr;
        logic [DW-1:0] wdata;
        logic          rw;     // 1 = read
        logic          word;   // 1 = 16-bit access
        logic          strobe;
    } bus_out_t;
endpackage
`default_nettype wire

// File: dma_step.sv
`default_nettype none
module dma_step
    import dma_pkg::*;
(
    input  wire logic [AW-1:0] val,
    input  wire dir_t          dir,
    input  wire logic [1:0]    amt,
    output logic      [AW-1:0] res
);
    // fixed direction passes the value through untouched
    always_comb begin
        case (dir)
            DIR_FWD: res = val + {{(AW - 2){1'b0}}, amt};
            DIR_BWD: res = val - {{(AW - 2){1'b0}}, amt};
            default: res = val;
        endcase
    end
endmodule
`default_nettype wire

// File: dma_seq_checker.sv
`default_nettype none
module dma_seq_checker
    import dma_pkg::*;
(
    input wire logic            ref_clk,
    input wire logic            rstn,
    input wire logic            refresh_req,
    input wire logic [NCH-1:0]  ext_transfer_request_n,
    input wire mode_t [NCH-1:0] chan_mode,
    input wire logic            terminal_count_line_o,
    input wire logic            terminal_count_line_oe_n,
    input wire bus_out_t        bus_o,
    input wire logic            bus_ack,
    input wire logic [7:0]      ctrl_r,
    input wire logic [NCH-1:0]  perm_r,
    input wire logic [NCH-1:0]  irq_set_r,
    input wire logic [NCH-1:0]  req_flag_r,
    input wire logic [CHW-1:0]  active_ch_r,
    input wire logic            busy_r
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    logic [NCH-1:0] perm_q;
    logic [NCH-1:0] rep_mask;
    // permission as seen in the idle cycle that decides a start
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            perm_q <= FLAG_RST;
        end else begin
            perm_q <= perm_r;
        end
    end
    // channels set to repeat
    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            rep_mask[i] = chan_mode[i].repeat_en;
        end
    end
    AST_START_PERM: assert property ($rose(busy_r) |-> perm_q[active_ch_r])
        else $error("unit began without permission");
    AST_START_REFRESH: assert property ($rose(busy_r) |-> !$past(refresh_req))
        else $error("unit began during refresh");
    AST_TC_VALID: assert property (!terminal_count_line_oe_n |-> ctrl_r[CTRL_TCV_BIT])
        else $error("terminal count driven while invalid");
    AST_TC_IRQ: assert property ($fell(terminal_count_line_oe_n) |->
        irq_set_r != FLAG_RST && !terminal_count_line_o ##1 terminal_count_line_oe_n)
        else $error("terminal count without irq");
    AST_IRQ_PERM: assert property (irq_set_r != FLAG_RST |-> (irq_set_r & perm_r) == 4'h0)
        else $error("permission kept at completion");
    AST_REPEAT_IRQ: assert property ((irq_set_r & rep_mask) == FLAG_RST)
        else $error("irq in repeat mode");
    AST_READ_FIRST: assert property ($rose(bus_o.strobe) |-> bus_o.rw && busy_r)
        else $error("unit did not start with read");
    AST_ADDR_HOLD: assert property (bus_o.strobe && !bus_ack |=>
        $stable(bus_o.addr) && $stable(bus_o.rw) && bus_o.strobe)
        else $error("access changed before ack");
    AST_IDLE_QUIET: assert property (!busy_r |-> !bus_o.strobe)
        else $error("strobe outside unit");
    AST_REQ_EDGE: assert property ($fell(ext_transfer_request_n[0]) && !busy_r
        |-> ##[1:4] req_flag_r[0])
        else $error("request edge lost");
    cover property (irq_set_r != FLAG_RST);
    cover property (bus_o.strobe && bus_ack && !bus_o.word);
    cover property (!terminal_count_line_oe_n);
endmodule
bind dma_seq dma_seq_checker chk (
    .ref_clk, .rstn, .refresh_req, .ext_transfer_request_n, .chan_mode,
    .terminal_count_line_o, .terminal_count_line_oe_n, .bus_o, .bus_ack, .ctrl_r,
    .perm_r, .irq_set_r, .req_flag_r, .active_ch_r, .busy_r
);
`default_nettype wire

// File: dma_mem_model.sv
`default_nettype none
module dma_mem_model
    import dma_pkg::*;
(
    input wire logic      ref_clk,
    input wire logic      rstn,
    input wire logic      slow,
    input wire bus_out_t  bus_o,
    output logic [DW-1:0] bus_rdata,
    output logic          bus_ack,
    output logic [AW-1:0] last_raddr,
    output logic [AW-1:0] last_waddr,
    output logic [DW-1:0] last_wdata,
    output logic [7:0]    n_wr
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       ready_r;
    logic [7:0] cyc_r;
    // slow mode holds each access one extra cycle
    assign bus_ack = bus_o.strobe && ready_r;
    // byte lanes mirror the address; noise when not read, never a stale value
    assign bus_rdata = (bus_o.strobe && bus_o.rw) ?
        {bus_o.addr[7:0] + 8'h01, bus_o.addr[7:0]} : {cyc_r, ~cyc_r};
    // access log for the bench
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            ready_r <= 1'b0;
            cyc_r <= 8'h00;
            last_raddr <= PTR_RST;
            last_waddr <= PTR_RST;
            last_wdata <= DATA_RST;
            n_wr <= 8'h00;
        end else begin
            cyc_r <= cyc_r + 8'h01;
            ready_r <= slow ? (bus_o.strobe && !bus_ack) : 1'b1;
            if (bus_ack && bus_o.rw) begin
                last_raddr <= bus_o.addr;
            end
            if (bus_ack && !bus_o.rw) begin
                last_waddr <= bus_o.addr;
                last_wdata <= bus_o.wdata;
                n_wr <= n_wr + 8'h01;
            end
        end
    end
endmodule
`default_nettype wire

// File: dma_seq_test.sv
`default_nettype none
module dma_seq_test
    import dma_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk, rstn, sw_wr, ctrl_wr, refresh_req, tc_ext, slow, busy_r, oe_n, tc_o, hold;
    logic [CHW-1:0] sw_wr_ch, active_ch_r;
    sw_sel_t        sw_wr_sel;
    logic [AW-1:0]  sw_wr_data, last_raddr, last_waddr;
    logic [7:0]     ctrl_wdata, ctrl_r, n_wr;
    logic [NCH-1:0] perm_set, perm_clr, ext_transfer_request_n, perm_r, req_flag_r, irq_set_r;
    mode_t [NCH-1:0] chan_mode;
    bus_out_t       bus_o;
    logic [DW-1:0]  bus_rdata, last_wdata;
    logic           bus_ack;
    wire            tc_pin;
    int             n_mismatch, total_checks, n_irq, n_tc;
    // open-drain pin with pull-up
    assign tc_pin = tc_ext & (oe_n | tc_o);
    dma_seq dut (.ref_clk, .rstn, .sw_wr, .sw_wr_ch, .sw_wr_sel, .sw_wr_data, .ctrl_wr,
        .ctrl_wdata, .perm_set, .perm_clr, .chan_mode, .ext_transfer_request_n, .refresh_req,
        .bus_hold_request(hold), .terminal_count_line_i(tc_pin), .terminal_count_line_o(tc_o),
        .terminal_count_line_oe_n(oe_n), .bus_o, .bus_rdata, .bus_ack, .ctrl_r, .perm_r,
        .req_flag_r, .irq_set_r, .active_ch_r, .busy_r);
    dma_mem_model mem (.ref_clk, .rstn, .slow, .bus_o, .bus_rdata, .bus_ack, .last_raddr,
        .last_waddr, .last_wdata, .n_wr);
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    // completion events, one-cycle pulses
    always @(negedge ref_clk) begin
        if (irq_set_r !== FLAG_RST) n_irq++;
        if (oe_n === 1'b0) n_tc++;
    end
    task automatic chk(input string what, input logic [AW-1:0] seen, input logic [AW-1:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // bounded waits; running out counts as a mismatch
    task automatic wait_wr(input logic [7:0] n);
        int i;
        for (i = 0; i < 300 && n_wr !== n; i++) @(negedge ref_clk);
        if (i == 300) chk("write count", n_wr, n);
        if (i == 300) give_verdict();
    endtask
    task automatic wait_busy();
        int i;
        for (i = 0; i < 300 && busy_r !== 1'b1; i++) @(negedge ref_clk);
        if (i == 300) chk("busy", busy_r, 1'b1);
        if (i == 300) give_verdict();
    endtask
    // pointers then counter, back to back on one held strobe
    task automatic setup(input logic [1:0] ch, input logic [AW-1:0] sp, dp, cnt);
        sw_wr_ch = ch;
        for (int s = 0; s < 3; s++) begin
            @(negedge ref_clk);
            {sw_wr, sw_wr_data} = {1'b1, (s == 0) ? sp : (s == 1) ? dp : cnt};
            sw_wr_sel = sw_sel_t'(s);
        end
        @(negedge ref_clk);
        sw_wr = 1'b0;
    endtask
    task automatic pulse_perm(input logic [NCH-1:0] s, c);
        @(negedge ref_clk);
        {perm_set, perm_clr} = {s, c};
        @(negedge ref_clk);
        {perm_set, perm_clr} = 8'h00;
    endtask
    task automatic pin_pulse(input int ch);
        @(negedge ref_clk);
        ext_transfer_request_n[ch] = 1'b0;
        repeat (6) @(negedge ref_clk);
        ext_transfer_request_n[ch] = 1'b1;
    endtask
    initial begin
        {rstn, sw_wr, refresh_req, slow, hold, perm_set, perm_clr, sw_wr_ch, sw_wr_data} = 0;
        {ctrl_wr, ctrl_wdata, tc_ext, ext_transfer_request_n} = {1'b1, 8'h02, 5'h1F};
        sw_wr_sel = SEL_SRC;
        chan_mode[0] = '{DIR_FWD, DIR_FWD, 1'b0, 1'b1, 1'b0, 1'b1};
        chan_mode[1] = '{DIR_BWD, DIR_FIX, 1'b0, 1'b0, 1'b1, 1'b0};
        chan_mode[3:2] = {chan_mode[0], chan_mode[0]};
        repeat (3) @(negedge ref_clk);
        rstn = 1'b1;
        chk("ctrl reset", ctrl_r, CTRL_RST);
        chk("perm reset", perm_r, FLAG_RST);
        // odd source splits each word read; counter runs out after two units
        setup(2'h0, 24'h000101, 24'h000200, 24'h000004);
        pulse_perm(4'h1, 4'h0);
        ctrl_wr = 1'b0;
        for (int r = 1; r <= 2; r++) begin
            if (r == 2) pulse_perm(4'h1, 4'h0);
            pin_pulse(0);
            wait_wr(8'(2 * r));
            repeat (3) @(negedge ref_clk);
            chk("dst addr", last_waddr, 24'h000202);
            chk("split data", last_wdata, 24'h000403);
            chk("src addr", last_raddr, 24'h000104);
            chk("perm done", perm_r[0], 1'b0);
            chk("flag done", req_flag_r[0], 1'b0);
            chk("irq count", n_irq, r);
            chk("tc count", n_tc, r);
        end
        // byte repeat, cycle steal, slow memory, fixed source and backward destination
        slow = 1'b1;
        setup(2'h1, 24'h0003A5, 24'h0004FF, 24'h000002);
        pulse_perm(4'h2, 4'h0);
        for (int k = 0; k < 3; k++) begin
            pin_pulse(1);
            wait_wr(8'(5 + k));
            repeat (3) @(negedge ref_clk);
            chk("steal dst", last_waddr, 24'h0004FF - 24'(k % 2));
            chk("fixed src", last_raddr, 24'h0003A5);
            chk("byte data", last_wdata[7:0], 8'hA5);
            chk("steal flag", req_flag_r[1], 1'b0);
        end
        chk("repeat perm", perm_r[1], 1'b1);
        chk("repeat irq", n_irq, 2);
        // two channels pending behind hold, then refresh, then both halted
        slow = 1'b0;
        setup(2'h2, 24'h000500, 24'h000600, 24'h000010);
        setup(2'h3, 24'h000700, 24'h000800, 24'h000010);
        pulse_perm(4'hC, 4'h0);
        {hold, ext_transfer_request_n[3:2]} = 3'b100;
        repeat (8) @(negedge ref_clk);
        chk("bus hold", n_wr, 8'h07);
        {hold, refresh_req} = 2'b01;
        repeat (8) @(negedge ref_clk);
        chk("refresh hold", n_wr, 8'h07);
        refresh_req = 1'b0;
        wait_busy();
        chk("priority", active_ch_r, 2'h2);
        pulse_perm(4'h0, 4'h4);
        repeat (8) @(negedge ref_clk);
        wait_busy();
        chk("next channel", active_ch_r, 2'h3);
        tc_ext = 1'b0;
        repeat (4) @(negedge ref_clk);
        tc_ext = 1'b1;
        repeat (8) @(negedge ref_clk);
        chk("halted perms", perm_r[3:2], 2'b00);
        chk("halt irq", n_irq, 2);
        chk("bus idle", bus_o.strobe, 1'b0);
        give_verdict();
    end
endmodule
`default_nettype wire
